/* core/i2c_seq_map.svh */
`ifndef I2C_SEQ_MAP_SVH
`define I2C_SEQ_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_W 4
`define OFF_CTRL 4'h0
`define OFF_STAT 4'h1
`define OFF_BAUD 4'h2
`define OFF_DATA 4'h3
// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define CTL_START 0
`define CTL_RESTART 1
`define CTL_RECV 2
`define CTL_ACKSEQ 3
`define CTL_ACK_DATA_BIT 4
// ----------------------------------------
// Status register bit positions (bits 0 to 6 write one to clear)
// ----------------------------------------
`define ST_START_DET 0
`define ST_IRQ 1
`define ST_BCOL 2
`define ST_BFULL 3
`define ST_WRITE_COLLISION_FLAG 4
`define ST_OVFL 5
`define ST_ACK_STATUS_BIT 6
`define ST_BUSY 7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define BAUD_RESET 8'h09
`endif

/* core/i2c_seq_pkg.sv */
package i2c_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_S_WAIT, ST_S_HOLD,
    ST_R_SCLLO, ST_R_SDAHI, ST_R_SCLHI, ST_R_SDALO,
    ST_T_LOW, ST_T_HIGH, ST_RX_PH, ST_A_LOW, ST_A_HIGH
  } seq_state_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } line_drive_t;
endpackage

/* core/i2c_master_sequencer.sv */
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "i2c_seq_map.svh"
// Operation
// - Start enable with both lines high loads baud counter from reload register.
// - Lines still high at expiry: pull data low, set start-detected flag.
// - Reload counter; on expiry clear start enable, stop counter, keep data low.
// - Line low at start or clock low early: collision flag, abort, idle.
// - Restart enable acts only when idle; otherwise ignored.
// - Restart: clock low, release data one period, release clock, wait high period.
// - Then data low one period, clock low, clear restart enable, hold data low.
// - Restart sets start-detected at the start, interrupt flag after expiry.
// - Restart collision on data low at clock rise or early clock fall.
// - Data write sets buffer-full and starts the counter for transmission.
// - Bits change in the same cycle the clock is pulled low; clock low one period, high one period.
// - At eighth falling edge clear buffer-full and release data.
// - Capture ninth clock level; ack status clear on ack, set on nack.
// - After ninth clock set interrupt flag, stop counter, hold clock low.
// - First byte shifts seven address bits then direction bit, msb first.
// - Data write while shifting sets write collision, buffer unchanged.
// - Receive enable ignored unless port idle.
// - Reception: each expiry toggles clock, data level shifted in.
// - After eighth received fall: clear enable, load buffer, set flags, hold clock.
// - Reading the data buffer clears buffer-full in reception.
// - Byte complete while buffer-full set raises receive overflow flag.
// - Released clock pauses counter until sampled high, then reloads.
// - Ack sequence: clock low, ack data on line, timed phases, clear, idle.
module i2c_master_sequencer
  import i2c_seq_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [`ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
    end
  end
  wire scl_hi = scl_sync_q[1];
  wire sda_hi = sda_sync_q[1];
  wire scl_rise = scl_hi && !scl_prev_q;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  reg_req_t req;
  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  function automatic logic hit(input reg_req_t r, input logic [3:0] off);
    hit = (r.addr == off);
  endfunction
  wire wr_ctrl = req.wr && hit(req, `OFF_CTRL);
  wire wr_stat = req.wr && hit(req, `OFF_STAT);
  wire wr_baud = req.wr && hit(req, `OFF_BAUD);
  wire wr_data = req.wr && hit(req, `OFF_DATA);
  wire rd_data = req.rd && hit(req, `OFF_DATA);

  // ----------------------------------------
  // State
  // ----------------------------------------
  seq_state_t state_q, state_d;
  logic [7:0] baud_q, cnt_q, cnt_d;
  logic run_q, run_d;
  logic [7:0] buf_q, buf_d, shift_q, shift_d;
  logic [3:0] bit_q, bit_d;
  logic [4:0] ctl_q, ctl_d;
  logic [6:0] st_q, st_d;
  line_drive_t drv_q, drv_d;
  logic [7:0] rdata_d;

  wire idle = (state_q == ST_IDLE);
  // Counter expiry marks the end of one baud period of reload+1 cycles.
  wire expire = run_q && (cnt_q == 8'h00);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = run_q ? cnt_q - 8'h01 : cnt_q;
    run_d = run_q;
    buf_d = buf_q;
    shift_d = shift_q;
    bit_d = bit_q;
    ctl_d = ctl_q;
    st_d = st_q;
    drv_d = drv_q;
    rdata_d = 8'h00;
    // Software clears status flags by writing ones; hardware sets below win.
    if (wr_stat) begin
      st_d = st_q & ~req.wdata[6:0];
    end
    if (rd_data) begin
      st_d[`ST_BFULL] = 1'b0;
    end
    if (wr_ctrl) begin
      ctl_d[`CTL_ACK_DATA_BIT] = req.wdata[`CTL_ACK_DATA_BIT];
    end
    case (state_q)
      ST_IDLE: begin
        run_d = 1'b0;
        if (wr_ctrl && req.wdata[`CTL_START]) begin
          ctl_d[`CTL_START] = 1'b1;
          if (scl_hi && sda_hi) begin
            cnt_d = baud_q;
            run_d = 1'b1;
            state_d = ST_S_WAIT;
          end else begin
            st_d[`ST_BCOL] = 1'b1;
            ctl_d[`CTL_START] = 1'b0;
          end
        end else if (wr_ctrl && req.wdata[`CTL_RESTART]) begin
          ctl_d[`CTL_RESTART] = 1'b1;
          drv_d.scl_oe = 1'b1;
          state_d = ST_R_SCLLO;
        end else if (wr_ctrl && req.wdata[`CTL_RECV]) begin
          ctl_d[`CTL_RECV] = 1'b1;
          drv_d.sda_oe = 1'b0;
          bit_d = 4'h0;
          cnt_d = baud_q;
          run_d = 1'b1;
          state_d = ST_RX_PH;
        end else if (wr_ctrl && req.wdata[`CTL_ACKSEQ]) begin
          ctl_d[`CTL_ACKSEQ] = 1'b1;
          drv_d.scl_oe = 1'b1;
          drv_d.sda_oe = ~req.wdata[`CTL_ACK_DATA_BIT];
          cnt_d = baud_q;
          run_d = 1'b1;
          state_d = ST_A_LOW;
        end else if (wr_data) begin
          buf_d = req.wdata;
          shift_d = req.wdata;
          st_d[`ST_BFULL] = 1'b1;
          bit_d = 4'h0;
          drv_d.scl_oe = 1'b1;
          drv_d.sda_oe = ~req.wdata[7];
          cnt_d = baud_q;
          run_d = 1'b1;
          state_d = ST_T_LOW;
        end
      end
      ST_S_WAIT: begin
        if (!scl_hi) begin
          st_d[`ST_BCOL] = 1'b1;
          ctl_d[`CTL_START] = 1'b0;
          drv_d = '0;
          state_d = ST_IDLE;
        end else if (!sda_hi || expire) begin
          drv_d.sda_oe = 1'b1;
          st_d[`ST_START_DET] = 1'b1;
          cnt_d = baud_q;
          state_d = ST_S_HOLD;
        end
      end
      ST_S_HOLD: begin
        if (expire) begin
          ctl_d[`CTL_START] = 1'b0;
          st_d[`ST_IRQ] = 1'b1;
          drv_d.scl_oe = 1'b1;
          run_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_R_SCLLO: begin
        if (!scl_hi) begin
          drv_d.sda_oe = 1'b0;
          cnt_d = baud_q;
          run_d = 1'b1;
          state_d = ST_R_SDAHI;
        end
      end
      ST_R_SDAHI: begin
        if (expire && sda_hi) begin
          drv_d.scl_oe = 1'b0;
          run_d = 1'b0;
          state_d = ST_R_SCLHI;
        end
      end
      ST_R_SCLHI: begin
        if (scl_rise && !sda_hi) begin
          st_d[`ST_BCOL] = 1'b1;
          ctl_d[`CTL_RESTART] = 1'b0;
          drv_d = '0;
          state_d = ST_IDLE;
        end else if (scl_hi && !run_q) begin
          cnt_d = baud_q;
          run_d = 1'b1;
        end else if (run_q && !scl_hi) begin
          st_d[`ST_BCOL] = 1'b1;
          ctl_d[`CTL_RESTART] = 1'b0;
          drv_d = '0;
          run_d = 1'b0;
          state_d = ST_IDLE;
        end else if (expire) begin
          drv_d.sda_oe = 1'b1;
          st_d[`ST_START_DET] = 1'b1;
          cnt_d = baud_q;
          state_d = ST_R_SDALO;
        end
      end
      ST_R_SDALO: begin
        if (expire) begin
          drv_d.scl_oe = 1'b1;
          ctl_d[`CTL_RESTART] = 1'b0;
          st_d[`ST_IRQ] = 1'b1;
          run_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_T_LOW: begin
        if (expire) begin
          drv_d.scl_oe = 1'b0;
          run_d = 1'b0;
          state_d = ST_T_HIGH;
        end
      end
      ST_T_HIGH: begin
        if (!run_q) begin
          if (scl_hi) begin
            cnt_d = baud_q;
            run_d = 1'b1;
            if (bit_q == 4'h8) begin
              st_d[`ST_ACK_STATUS_BIT] = sda_hi;
            end
          end
        end else if (expire) begin
          drv_d.scl_oe = 1'b1;
          cnt_d = baud_q;
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h8) begin
            st_d[`ST_IRQ] = 1'b1;
            run_d = 1'b0;
            state_d = ST_IDLE;
          end else if (bit_q == 4'h7) begin
            st_d[`ST_BFULL] = 1'b0;
            drv_d.sda_oe = 1'b0;
            state_d = ST_T_LOW;
          end else begin
            shift_d = {shift_q[6:0], 1'b0};
            drv_d.sda_oe = ~shift_q[6];
            state_d = ST_T_LOW;
          end
        end
      end
      ST_RX_PH: begin
        if (!run_q) begin
          if (scl_hi) begin
            cnt_d = baud_q;
            run_d = 1'b1;
          end
        end else if (expire) begin
          cnt_d = baud_q;
          if (drv_q.scl_oe) begin
            drv_d.scl_oe = 1'b0;
            run_d = 1'b0;
          end else begin
            drv_d.scl_oe = 1'b1;
            shift_d = {shift_q[6:0], sda_hi};
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              ctl_d[`CTL_RECV] = 1'b0;
              buf_d = {shift_q[6:0], sda_hi};
              st_d[`ST_OVFL] = st_q[`ST_BFULL] | st_d[`ST_OVFL];
              st_d[`ST_BFULL] = 1'b1;
              st_d[`ST_IRQ] = 1'b1;
              run_d = 1'b0;
              state_d = ST_IDLE;
            end
          end
        end
      end
      ST_A_LOW: begin
        if (expire) begin
          drv_d.scl_oe = 1'b0;
          run_d = 1'b0;
          state_d = ST_A_HIGH;
        end
      end
      ST_A_HIGH: begin
        if (!run_q) begin
          if (scl_hi) begin
            cnt_d = baud_q;
            run_d = 1'b1;
          end
        end else if (expire) begin
          drv_d.scl_oe = 1'b1;
          ctl_d[`CTL_ACKSEQ] = 1'b0;
          st_d[`ST_IRQ] = 1'b1;
          run_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        drv_d = '0;
        run_d = 1'b0;
      end
    endcase
    // A buffer write outside idle is refused and flagged.
    if (wr_data && !idle) begin
      st_d[`ST_WRITE_COLLISION_FLAG] = 1'b1;
    end
    if (req.rd) begin
      case (req.addr)
        `OFF_CTRL: rdata_d = {3'h0, ctl_q};
        `OFF_STAT: rdata_d = {!idle, st_q};
        `OFF_BAUD: rdata_d = baud_q;
        `OFF_DATA: rdata_d = buf_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      buf_q <= 8'h00;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      ctl_q <= 5'h00;
      st_q <= 7'h00;
      drv_q <= '0;
      rdata_out <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      buf_q <= buf_d;
      shift_q <= shift_d;
      bit_q <= bit_d;
      ctl_q <= ctl_d;
      st_q <= st_d;
      drv_q <= drv_d;
      rdata_out <= rdata_d;
    end
  end

  // Reload changes take effect at the next period, never mid-count.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      baud_q <= `BAUD_RESET;
    end else if (wr_baud) begin
      baud_q <= req.wdata;
    end
  end

  // Lines are open drain: only low is ever driven.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_out <= drv_d.scl_oe;
      sda_oe_out <= drv_d.sda_oe;
    end
  end
endmodule

/* dv/i2c_slave_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Slave device on the two-wire bus
// ----------------------------------------
module i2c_slave_model (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic nack_in,
  input wire logic rx_mode_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic stretch_in,
  output logic scl_pull_out,
  output logic sda_pull_out
);
  int slot = 0;
  initial scl_pull_out = 1'b0;
  // A start condition restarts the slot count.
  // The check waits until both lines settle, because the master moves data as it pulls the clock low.
  always @(negedge sda_in) begin
    #1;
    if (scl_in === 1'b1 && sda_in === 1'b0) slot = 0;
  end
  always @(negedge scl_in) begin
    slot = (slot == 9) ? 1 : slot + 1;
    if (stretch_in) begin
      scl_pull_out = 1'b1;
      #900 scl_pull_out = 1'b0;
    end
  end
  // Data moves only while the clock is low, so no false start is ever made.
  assign sda_pull_out = rx_mode_in ? (slot >= 1 && slot <= 8 && !tx_byte_in[8 - slot])
                                   : (slot == 9 && !nack_in);
endmodule

/* dv/i2c_seq_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module i2c_seq_monitor
  import i2c_seq_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_out,
  input wire logic sda_oe_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  logic [7:0] baud_q;
  logic [9:0] lo_q;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) baud_q <= 8'h09;
    else if (wr_in && addr_in == 4'h2) baud_q <= wdata_in;
  end
  // Counts how long the clock line has been pulled low by the master.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !scl_oe_out) lo_q <= 10'h000;
    else if (lo_q != 10'h3FF) lo_q <= lo_q + 10'h001;
  end
  sequence s_grab;
    $rose(sda_oe_out) && !scl_oe_out;
  endsequence
  property p_rdata;
    !rd_in |=> rdata_out == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data without read");
  property p_pins;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_pins: assert property (p_pins) else $error("pin output not low");
  property p_grab_line;
    s_grab |-> $past(scl_in, 2) && $past(scl_in, 3);
  endproperty
  a_grab_line: assert property (p_grab_line) else $error("data pulled with clock low");
  property p_grab_hold;
    s_grab |=> !scl_oe_out [*2];
  endproperty
  a_grab_hold: assert property (p_grab_hold) else $error("start hold too short");
  property p_low_min;
    $fell(scl_oe_out) |-> lo_q >= {2'b00, baud_q} + 10'h001;
  endproperty
  a_low_min: assert property (p_low_min) else $error("clock low shorter than period");
  property p_high_min;
    $rose(scl_oe_out) |-> $past(scl_in, 2) && $past(scl_in, 3) && $past(scl_in, 4);
  endproperty
  a_high_min: assert property (p_high_min) else $error("clock high cut short");
  property p_rel_hold;
    $fell(scl_oe_out) |=> !scl_oe_out [*3];
  endproperty
  a_rel_hold: assert property (p_rel_hold) else $error("clock released too briefly");
  property p_sda_rel;
    $fell(sda_oe_out) |-> scl_oe_out;
  endproperty
  a_sda_rel: assert property (p_sda_rel) else $error("data released with clock high");
endmodule
bind i2c_master_sequencer i2c_seq_monitor u_mon (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out));

/* dv/tb.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module tb;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, nack = 1'b0, rxm = 1'b0, strc = 1'b0, hold_scl = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, txb = 8'h00;
  logic [7:0] rdat, st, d, b;
  logic [8:0] sh = 9'h000;
  logic scl_oe, sda_oe, scl_pull, sda_pull;
  int error_cnt = 0;
  int n_checks = 0;
  wire scl = !(scl_oe | scl_pull | hold_scl);
  wire sda = !(sda_oe | sda_pull);
  always #25 clk = ~clk;
  always @(posedge scl) sh = {sh[7:0], sda};
  i2c_master_sequencer DUT (.clock_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wd), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdat), .scl_in(scl), .sda_in(sda), .scl_out(), .scl_oe_out(scl_oe),
    .sda_out(), .sda_oe_out(sda_oe));
  i2c_slave_model SLV (.scl_in(scl), .sda_in(sda), .nack_in(nack), .rx_mode_in(rxm), .tx_byte_in(txb),
    .stretch_in(strc), .scl_pull_out(scl_pull), .sda_pull_out(sda_pull));
  function automatic logic [7:0] exp_tx(input logic n, input logic w);
    return {1'b0, n, 1'b0, w, 4'b0010};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
    @(posedge clk);
  endtask
  task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
    int i;
    i = 0;
    do begin
      rreg(4'h1, st);
      i++;
    end while ((st & m) !== v && i < 400);
    chk(st & m, v);
  endtask
  task automatic results;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    error_cnt++;
    results();
  end
  initial begin
    void'($urandom(54));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(4'h2, d);
    chk(d, 8'h09);
    rreg(4'h1, d);
    chk(d, 8'h00);
    wreg(4'h2, 8'h03);
    wreg(4'hF, 8'hFF);
    rreg(4'h2, d);
    chk(d, 8'h03);
    wreg(4'h0, 8'h01);
    wreg(4'h3, 8'hA5);
    wreg(4'h0, 8'h06);
    wait_st(8'h02, 8'h02);
    chk(st & 8'h3F, 8'h13);
    rreg(4'h0, d);
    chk(d & 8'h07, 8'h00);
    wreg(4'h1, 8'h7F);
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom);
      nack <= 1'($urandom);
      strc <= (k == 2);
      wreg(4'h3, b);
      rreg(4'h1, d);
      chk(d & 8'h08, 8'h08);
      if (k == 1) wreg(4'h3, ~b);
      wait_st(8'h02, 8'h02);
      chk(st & 8'h7F, exp_tx(nack, k == 1));
      chk(sh[8:1], b);
      chk({7'h00, sh[0]}, {7'h00, nack});
      rreg(4'h3, d);
      chk(d, b);
      wreg(4'h1, 8'h7F);
    end
    rxm <= 1'b1;
    strc <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      txb <= 8'($urandom);
      wreg(4'h0, 8'h04);
      if (k == 1) wreg(4'h0, 8'h01);
      wait_st(8'h02, 8'h02);
      chk(st & 8'h2B, (k == 2) ? 8'h2A : 8'h0A);
      chk(sh[7:0], txb);
      if (k == 0) begin
        rreg(4'h3, d);
        chk(d, txb);
        rreg(4'h1, d);
        chk(d & 8'h08, 8'h00);
      end
      wreg(4'h1, 8'h02);
      wreg(4'h0, {3'b000, k[0], 4'h8});
      wait_st(8'h80, 8'h00);
      chk({7'h00, sh[0]}, {7'h00, k[0]});
      wreg(4'h1, 8'h02);
    end
    rxm <= 1'b0;
    wreg(4'h1, 8'h7F);
    wreg(4'h0, 8'h02);
    wait_st(8'h02, 8'h02);
    chk(st & 8'h07, 8'h03);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    hold_scl <= 1'b1;
    @(posedge clk);
    rreg(4'h2, d);
    chk(d, 8'h09);
    wreg(4'h0, 8'h01);
    wait_st(8'h84, 8'h04);
    hold_scl <= 1'b0;
    results();
  end
endmodule
